// >>> core/fdm_map.vh
// Behaviour
// - user code rewrites the 512-byte region 8000h-81ffh in whole 64-byte pages.
// - serial programming mode accepts writes to the region like program memory.
// - key field decodes 0011 as write enable, 1100 as disable, others reserved.
// - writing 1 to forced stop aborts a write and clears the write data counter.
// - forced stop bit returns to 0 by itself after a 1 is written.
// - auto keep 0 powers control circuit off in idle/sleep; 1 keeps it on.
// - manual power bit 1 powers the control circuit on, 0 powers it off.
// - key, forced stop and manual power change only while fetching from ram/boot.
// - auto keep bit only matters while manual power bit is 1.
// - stop mode powers the control circuit off regardless of auto keep.
// - control reads give bit 3 undefined and bit 2 always 0.
// - power ready rises after 2^10 main clocks or 2^3 slow clock ticks.
// - reads of the flash area return ffh while write busy is set.
`ifndef FDM_MAP_VH
`define FDM_MAP_VH
`define FDM_OFF_CTRL      8'h00
`define FDM_OFF_STAT      8'h04
`define FDM_OFF_IRQ       8'h08
`define FDM_OFF_MASK      8'h0c
`define FDM_CTRL_KEY_HI   7
`define FDM_CTRL_KEY_LO   4
`define FDM_CTRL_UNDEF    3
`define FDM_CTRL_STOP     2
`define FDM_CTRL_AUTO     1
`define FDM_CTRL_MANUAL   0
`define FDM_STAT_BUSY     0
`define FDM_STAT_READY    1
`define FDM_STAT_WRITE_INTERRUPTED     2
`define FDM_IRQ_DONE      0
`define FDM_IRQ_WRITE_INTERRUPTED      1
`define FDM_IRQ_READY     2
`define FDM_KEY_RESET     4'hc
`define FDM_KEY_ENABLE    4'h3
`define FDM_KEY_DISABLE   4'hc
`define FDM_AUTO_RESET    1'h1
`define FDM_MANUAL_RESET  1'h1
`define FDM_REGION_BASE   16'h8000
`define FDM_REGION_LAST   16'h81ff
`define FDM_PAGE_BYTES    7'h40
`define FDM_WARM_MAIN     10'h3ff
`define FDM_WARM_SLOW     10'h007
`define FDM_WRITE_TIME_NS 4000000
`define FDM_CLK_PERIOD_NS 50
`endif

// >>> core/fdm_sync.v
`timescale 1ns/10ps
module fdm_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire d_i,
  output reg  q_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // a change counts once the second and third stage agree
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule // fdm_sync

// >>> core/fdm_ctrl.v
`timescale 1ns/10ps
`include "fdm_map.vh"
module fdm_ctrl #(
  parameter WRITE_CYCLES = `FDM_WRITE_TIME_NS / `FDM_CLK_PERIOD_NS
) (
  input  wire        CLK_I,
  input  wire        RST_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output wire        PREADY_O,
  output reg         PSLVERR_O,
  input  wire        FETCH_RAM_I,
  input  wire        IDLE_I,
  input  wire        SLEEP_I,
  input  wire        STOP_I,
  input  wire        SLOW_CLK_SEL_I,
  input  wire        SLOW_TICK_I,
  input  wire        NMI_I,
  input  wire        SERIAL_MODE_I,
  input  wire        MEM_SEL_I,
  input  wire        MEM_WR_I,
  input  wire [15:0] MEM_ADDR_I,
  input  wire [7:0]  MEM_WDATA_I,
  output reg  [7:0]  MEM_RDATA_O,
  output reg         FLASH_POWER_O,
  output wire        IRQ_O
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FILL = 2'h1;
  localparam [1:0] ST_PROG = 2'h2;
  localparam [16:0] WR_LAST = WRITE_CYCLES[16:0] - 17'h00001;

  function in_region;
    input [15:0] a;
    begin
      in_region = (a >= `FDM_REGION_BASE) && (a <= `FDM_REGION_LAST);
    end
  endfunction

  function is_reg;
    input [7:0] a;
    input [7:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  reg [7:0]  flash_mem [0:511];
  reg [7:0]  page_buf  [0:63];

  reg [3:0]  key_reg;
  reg        auto_keep_reg;
  reg        manual_on_reg;
  reg        stop_pulse_reg;
  reg [1:0]  state_reg;
  reg [6:0]  byte_cnt_reg;
  reg [2:0]  page_reg;
  reg [16:0] prog_cnt_reg;
  reg        ready_reg;
  reg [9:0]  warm_cnt_reg;
  reg        write_interrupted_reg;
  reg [2:0]  irq_stat_reg;
  reg [2:0]  irq_mask_reg;
  reg        ready_d_reg;

  wire       serial_mode;
  wire       setup_ph;
  wire       access_ph;
  wire       wr_access;
  wire       rd_access;
  wire       mapped;
  wire       key_enabled;
  wire       busy;
  wire       flash_on_next;
  wire       wr_accept;
  wire       prog_done;
  wire       write_abort;
  wire       nmi_abort;
  wire [2:0] irq_event;
  integer    i;

  fdm_sync u_serial_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (SERIAL_MODE_I),
    .q_o   (serial_mode)
  );

  assign setup_ph  = PSEL_I & ~PENABLE_I;
  assign access_ph = PSEL_I & PENABLE_I;
  assign wr_access = access_ph & PWRITE_I;
  assign rd_access = access_ph & ~PWRITE_I;
  assign PREADY_O  = 1'b1;
  assign mapped    = is_reg(PADDR_I, `FDM_OFF_CTRL) |
                     is_reg(PADDR_I, `FDM_OFF_STAT) |
                     is_reg(PADDR_I, `FDM_OFF_IRQ) |
                     is_reg(PADDR_I, `FDM_OFF_MASK);

  // only the exact enable code opens the region for writing, except in serial mode
  assign key_enabled = (key_reg == `FDM_KEY_ENABLE);

  assign busy = (state_reg != ST_IDLE);

  // manual bit gates everything; stop forces off; idle/sleep unless kept
  assign flash_on_next = manual_on_reg & ~STOP_I &
                         ~((IDLE_I | SLEEP_I) & ~auto_keep_reg);

  assign wr_accept = MEM_SEL_I & MEM_WR_I & in_region(MEM_ADDR_I) &
                     (key_enabled | serial_mode) & ready_reg &
                     (state_reg != ST_PROG);

  assign prog_done   = (state_reg == ST_PROG) & (prog_cnt_reg == WR_LAST);
  assign nmi_abort   = busy & NMI_I;
  assign write_abort = stop_pulse_reg | nmi_abort;

  assign irq_event = {ready_reg & ~ready_d_reg, nmi_abort, prog_done};

  // control register, protected fields follow the fetch area
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      key_reg        <= `FDM_KEY_RESET;
      auto_keep_reg  <= `FDM_AUTO_RESET;
      manual_on_reg  <= `FDM_MANUAL_RESET;
      stop_pulse_reg <= 1'b0;
    end else begin
      stop_pulse_reg <= 1'b0;
      if (wr_access && is_reg(PADDR_I, `FDM_OFF_CTRL)) begin
        auto_keep_reg <= PWDATA_I[`FDM_CTRL_AUTO];
        if (FETCH_RAM_I) begin
          key_reg        <= PWDATA_I[`FDM_CTRL_KEY_HI:`FDM_CTRL_KEY_LO];
          manual_on_reg  <= PWDATA_I[`FDM_CTRL_MANUAL];
          stop_pulse_reg <= PWDATA_I[`FDM_CTRL_STOP];
        end
      end
    end
  end

  // power switch and warm-up before ready
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FLASH_POWER_O <= 1'b0;
      ready_reg     <= 1'b0;
      ready_d_reg   <= 1'b0;
      warm_cnt_reg  <= 10'h000;
    end else begin
      FLASH_POWER_O <= flash_on_next;
      ready_d_reg   <= ready_reg;
      if (!FLASH_POWER_O) begin
        ready_reg    <= 1'b0;
        warm_cnt_reg <= 10'h000;
      end else if (!ready_reg) begin
        if (SLOW_CLK_SEL_I) begin
          if (SLOW_TICK_I) begin
            if (warm_cnt_reg >= `FDM_WARM_SLOW) begin
              ready_reg <= 1'b1;
            end else begin
              warm_cnt_reg <= warm_cnt_reg + 10'h001;
            end
          end
        end else if (warm_cnt_reg == `FDM_WARM_MAIN) begin
          ready_reg <= 1'b1;
        end else begin
          warm_cnt_reg <= warm_cnt_reg + 10'h001;
        end
      end
    end
  end

  // page fill and programming sequence
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg    <= ST_IDLE;
      byte_cnt_reg <= 7'h00;
      page_reg     <= 3'h0;
      prog_cnt_reg <= 17'h00000;
    end else if (write_abort) begin
      state_reg    <= ST_IDLE;
      byte_cnt_reg <= 7'h00;
      prog_cnt_reg <= 17'h00000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_accept) begin
            page_reg     <= MEM_ADDR_I[8:6];
            byte_cnt_reg <= 7'h01;
            state_reg    <= ST_FILL;
          end
        end
        ST_FILL: begin
          if (wr_accept) begin
            byte_cnt_reg <= byte_cnt_reg + 7'h01;
            if (byte_cnt_reg == `FDM_PAGE_BYTES - 7'h01) begin
              state_reg    <= ST_PROG;
              prog_cnt_reg <= 17'h00000;
            end
          end
        end
        ST_PROG: begin
          if (prog_done) begin
            state_reg    <= ST_IDLE;
            byte_cnt_reg <= 7'h00;
          end else begin
            prog_cnt_reg <= prog_cnt_reg + 17'h00001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // byte lanes of the page buffer and the array itself
  always @(posedge CLK_I) begin
    if (wr_accept && !write_abort) begin
      page_buf[MEM_ADDR_I[5:0]] <= MEM_WDATA_I;
    end
    if (prog_done && !write_abort) begin
      for (i = 0; i < 64; i = i + 1) begin
        flash_mem[{page_reg, i[5:0]}] <= page_buf[i];
      end
    end
  end

  // flash area read port
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MEM_RDATA_O <= 8'hff;
    end else if (MEM_SEL_I && !MEM_WR_I) begin
      if (busy || !in_region(MEM_ADDR_I)) begin
        MEM_RDATA_O <= 8'hff;
      end else begin
        MEM_RDATA_O <= flash_mem[MEM_ADDR_I[8:0]];
      end
    end
  end

  // write interrupted flag: set wins over clear on status read
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      write_interrupted_reg <= 1'b0;
    end else if (nmi_abort) begin
      write_interrupted_reg <= 1'b1;
    end else if (rd_access && is_reg(PADDR_I, `FDM_OFF_STAT)) begin
      write_interrupted_reg <= 1'b0;
    end
  end

  // sticky interrupt status, write one to clear, event wins
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_irq
      always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          irq_stat_reg[g] <= 1'b0;
        end else if (irq_event[g]) begin
          irq_stat_reg[g] <= 1'b1;
        end else if (wr_access && is_reg(PADDR_I, `FDM_OFF_IRQ) &&
                     PWDATA_I[g]) begin
          irq_stat_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_mask_reg <= 3'h0;
    end else if (wr_access && is_reg(PADDR_I, `FDM_OFF_MASK)) begin
      irq_mask_reg <= PWDATA_I[2:0];
    end
  end

  assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

  // read data captured in setup phase, error flagged for unmapped offsets
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O  <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else if (setup_ph) begin
      PSLVERR_O <= ~mapped;
      PRDATA_O  <= 32'h00000000;
      if (is_reg(PADDR_I, `FDM_OFF_CTRL)) begin
        // undefined bit reads as 0, stop bit always 0
        PRDATA_O <= {24'h000000, key_reg, 1'b0, 1'b0,
                     auto_keep_reg, manual_on_reg};
      end else if (is_reg(PADDR_I, `FDM_OFF_STAT)) begin
        PRDATA_O <= {29'h00000000, write_interrupted_reg, ready_reg, busy};
      end else if (is_reg(PADDR_I, `FDM_OFF_IRQ)) begin
        PRDATA_O <= {29'h00000000, irq_stat_reg};
      end else if (is_reg(PADDR_I, `FDM_OFF_MASK)) begin
        PRDATA_O <= {29'h00000000, irq_mask_reg};
      end
    end else if (!PSEL_I) begin
      PSLVERR_O <= 1'b0;
    end
  end
endmodule // fdm_ctrl

// >>> verif/fdm_ctrl_assertions.sv
`timescale 1ns/10ps
module fdm_ctrl_assertions (
  input wire        CLK_I,
  input wire        RST_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [7:0]  PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire        PSLVERR_O,
  input wire        FETCH_RAM_I,
  input wire        IDLE_I,
  input wire        SLEEP_I,
  input wire        STOP_I,
  input wire        SLOW_CLK_SEL_I,
  input wire        MEM_SEL_I,
  input wire        MEM_WR_I,
  input wire [15:0] MEM_ADDR_I,
  input wire [7:0]  MEM_RDATA_O,
  input wire        FLASH_POWER_O
);
  reg [3:0]  key_reg;
  reg        man_reg;
  reg        keep_reg;
  reg [10:0] pcnt_reg;
  wire set = PSEL_I && !PENABLE_I;
  wire bad = PADDR_I[7:4] != 4'h0 || PADDR_I[1:0] != 2'h0;
  wire r0  = set && !PWRITE_I && PADDR_I == 8'h00;
  wire r4  = set && !PWRITE_I && PADDR_I == 8'h04;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // shadow of control bits and of how long power has been on
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      key_reg <= 4'hc;
      man_reg <= 1'b1;
      keep_reg <= 1'b1;
      pcnt_reg <= 11'h000;
    end else begin
      if (!FLASH_POWER_O)
        pcnt_reg <= 11'h000;
      else if (pcnt_reg != 11'h7ff)
        pcnt_reg <= pcnt_reg + 11'h001;
      if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h00) begin
        keep_reg <= PWDATA_I[1];
        if (FETCH_RAM_I) begin
          key_reg <= PWDATA_I[7:4];
          man_reg <= PWDATA_I[0];
        end
      end
    end
  end
  a_power_on: assert property (
    man_reg && !STOP_I && !((IDLE_I || SLEEP_I) && !keep_reg)
    |=> FLASH_POWER_O) else $error("power not on");
  a_manual_off: assert property (
    !man_reg |=> !FLASH_POWER_O) else $error("power on, manual off");
  a_stop_off: assert property (
    STOP_I |=> !FLASH_POWER_O) else $error("power on in stop");
  a_idle_off: assert property (
    (IDLE_I || SLEEP_I) && !keep_reg |=> !FLASH_POWER_O)
    else $error("power on in idle");
  a_ctrl_read: assert property (
    r0 |=> PRDATA_O[7:4] == key_reg && PRDATA_O[1:0] == {keep_reg, man_reg})
    else $error("control read wrong");
  a_stop_bit_zero: assert property (
    r0 |=> !PRDATA_O[2]) else $error("bit 2 read as one");
  a_outside_ff: assert property (
    MEM_SEL_I && !MEM_WR_I && MEM_ADDR_I[15:9] != 7'h40
    |=> MEM_RDATA_O == 8'hff) else $error("outside read not ff");
  a_unmapped_err: assert property (
    set && bad |=> PSLVERR_O) else $error("no error response");
  a_mapped_ok: assert property (
    set && !bad |=> !PSLVERR_O) else $error("error on mapped");
  a_warm_early: assert property (
    r4 && !SLOW_CLK_SEL_I && pcnt_reg < 11'h3e8 |=> !PRDATA_O[1])
    else $error("ready early");
  a_warm_done: assert property (
    r4 && pcnt_reg > 11'h44c |=> PRDATA_O[1]) else $error("ready late");
endmodule // fdm_ctrl_assertions
bind fdm_ctrl fdm_ctrl_assertions i_fdm_ctrl_assertions (
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .FETCH_RAM_I(FETCH_RAM_I),
  .IDLE_I(IDLE_I), .SLEEP_I(SLEEP_I), .STOP_I(STOP_I),
  .SLOW_CLK_SEL_I(SLOW_CLK_SEL_I),
  .MEM_SEL_I(MEM_SEL_I), .MEM_WR_I(MEM_WR_I), .MEM_ADDR_I(MEM_ADDR_I),
  .MEM_RDATA_O(MEM_RDATA_O), .FLASH_POWER_O(FLASH_POWER_O));

// >>> verif/fdm_core_model.sv
`timescale 1ns/10ps
module fdm_core_model (
  input  wire        clk_i,
  input  wire        go_i,
  input  wire        rd_i,
  input  wire [6:0]  n_i,
  input  wire [15:0] base_i,
  input  wire [7:0]  salt_i,
  output reg         sel_o = 1'b0,
  output reg         wr_o = 1'b0,
  output reg  [15:0] addr_o = 16'h0000,
  output reg  [7:0]  wdata_o = 8'h00,
  output wire        busy_o
);
  reg [6:0]  left_reg = 7'h00;
  reg        rd_reg = 1'b0;
  reg [15:0] next_reg = 16'h0000;
  assign busy_o = left_reg != 7'h00;
  // one byte strobe a cycle, ascending addresses
  always @(posedge clk_i) begin
    if (go_i) begin
      left_reg <= n_i;
      rd_reg <= rd_i;
      next_reg <= base_i;
    end else if (busy_o) begin
      left_reg <= left_reg - 7'h01;
      next_reg <= next_reg + 16'h0001;
    end
    sel_o <= busy_o;
    wr_o <= busy_o && !rd_reg;
    // released lines toggle so no stale value looks valid
    addr_o <= busy_o ? next_reg : ~addr_o;
    wdata_o <= busy_o ? next_reg[7:0] ^ salt_i : ~wdata_o;
  end
endmodule // fdm_core_model

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00, salt = 8'h00, raddr8;
  logic [31:0] pwdata = 32'h0, rd;
  logic        fetch = 1'b1, idle = 1'b0, sleep = 1'b0, stop = 1'b0;
  logic        nmi = 1'b0, smode = 1'b0, slow = 1'b0, tick = 1'b0;
  logic        go = 1'b0, mrd = 1'b0, exp_ff = 1'b1, er, rpend = 1'b0;
  logic [6:0]  mn = 7'h00;
  logic [15:0] mbase = 16'h0;
  logic [3:0]  rkey;
  logic [11:0] pt [5] = '{12'h933, 12'h231, 12'h433, 12'h030, 12'h132};
  wire [31:0]  prdata;
  wire [15:0]  maddr;
  wire [7:0]   mwdata, mrdata;
  wire         pready, pslverr, msel, mwr, mbusy, fpow, irq;
  int          fails = 0, n_checks = 0, cyc = 0, t0;
  fdm_ctrl #(.WRITE_CYCLES(20)) i_fdm_ctrl (.CLK_I(clk), .RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .FETCH_RAM_I(fetch), .IDLE_I(idle),
    .SLEEP_I(sleep), .STOP_I(stop), .SLOW_CLK_SEL_I(slow),
    .SLOW_TICK_I(tick), .NMI_I(nmi), .SERIAL_MODE_I(smode),
    .MEM_SEL_I(msel), .MEM_WR_I(mwr), .MEM_ADDR_I(maddr),
    .MEM_WDATA_I(mwdata), .MEM_RDATA_O(mrdata), .FLASH_POWER_O(fpow),
    .IRQ_O(irq));
  fdm_core_model i_fdm_core_model (.clk_i(clk), .go_i(go), .rd_i(mrd),
    .n_i(mn), .base_i(mbase), .salt_i(salt), .sel_o(msel), .wr_o(mwr),
    .addr_o(maddr), .wdata_o(mwdata), .busy_o(mbusy));
  initial forever #25 clk = ~clk;
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task final_report;
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task poll(input int b, input logic v);
    apb(1'b0, 8'h04, 32'h0);
    while (rd[b] !== v) apb(1'b0, 8'h04, 32'h0);
  endtask
  task core(input logic r, input logic [15:0] b, input logic [6:0] n);
    go <= 1'b1;
    mrd <= r;
    mbase <= b;
    mn <= n;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (mbusy) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rpend)
      chk("mem_rdata", mrdata, exp_ff ? 8'hff : raddr8 ^ salt);
    rpend <= msel & ~mwr;
    raddr8 <= maddr[7:0];
    cyc++;
    tick <= slow && (cyc % 4 == 0);
    if (cyc > 6000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    void'($urandom(32'hc56a1139));
    salt = 8'($urandom);
    rkey = 4'($urandom % 15);
    if (rkey > 4'h2) rkey++;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t0 = cyc;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_reset", rd, 32'hc3);
    apb(1'b0, 8'h0c, 32'h0);
    chk("mask_reset", rd, 32'h0);
    poll(1, 1'b1);
    chk("warmup", (cyc - t0 > 1024) ? 32'h1 : 32'h0, 32'h1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h00, {24'h0, i ? 4'hc : rkey, 4'h3});
      core(1'b0, 16'h8000, 7'h40);
      apb(1'b0, 8'h04, 32'h0);
      chk("busy_locked", rd[0], 1'b0);
    end
    fetch <= 1'b0;
    apb(1'b1, 8'h00, 32'h36);
    fetch <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_from_flash", rd, 32'hc3);
    apb(1'b1, 8'h00, 32'h33);
    core(1'b0, 16'h8040, 7'h40);
    apb(1'b0, 8'h04, 32'h0);
    chk("busy", rd[0], 1'b1);
    core(1'b1, 16'h8040, 7'h04);
    poll(0, 1'b0);
    exp_ff <= 1'b0;
    core(1'b1, 16'h8040, 7'h40);
    apb(1'b0, 8'h08, 32'h0);
    chk("irq_status", rd, 32'h5);
    chk("irq_masked", irq, 1'b0);
    apb(1'b1, 8'h0c, 32'h1);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, 8'h08, 32'h1);
    chk("irq_off", irq, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk("irq_w1c", rd, 32'h4);
    exp_ff <= 1'b1;
    core(1'b1, 16'h8200, 7'h08);
    core(1'b0, 16'h8080, 7'h0a);
    apb(1'b1, 8'h00, 32'h37);
    apb(1'b0, 8'h04, 32'h0);
    chk("stop_abort", rd[0], 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_stop", rd, 32'h33);
    core(1'b0, 16'h8080, 7'h40);
    repeat (30) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk("refill", rd[0], 1'b0);
    apb(1'b1, 8'h00, 32'hc3);
    smode <= 1'b1;
    repeat (6) @(posedge clk);
    core(1'b0, 16'h80c0, 7'h40);
    apb(1'b0, 8'h04, 32'h0);
    chk("serial_busy", rd[0], 1'b1);
    poll(0, 1'b0);
    smode <= 1'b0;
    apb(1'b1, 8'h00, 32'h33);
    core(1'b0, 16'h8100, 7'h0a);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk("nmi_abort", rd, 32'h6);
    apb(1'b0, 8'h04, 32'h0);
    chk("write_interrupted_clear", rd, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    chk("irq_write_interrupted", rd[1], 1'b1);
    repeat (4) begin
      apb(1'($urandom), 8'h10 + 8'($urandom % 60) * 8'h4, $urandom);
      chk("slverr", er, 1'b1);
    end
    // interrupts masked before manual power is cleared
    apb(1'b1, 8'h0c, 32'h0);
    foreach (pt[i]) begin
      apb(1'b1, 8'h00, {24'h0, pt[i][7:0]});
      {stop, sleep, idle} <= pt[i][10:8];
      repeat (3) @(posedge clk);
      chk("power", fpow, pt[i][11]);
    end
    {stop, sleep, idle} <= 3'h0;
    slow <= 1'b1;
    apb(1'b1, 8'h00, 32'h33);
    t0 = cyc;
    poll(1, 1'b1);
    chk("slow_warm", 32'(cyc - t0 >= 28 && cyc - t0 < 60), 32'h1);
    final_report;
  end
endmodule // tb_top
